// ### rtl/irq_enable_upper.sv
// Upper interrupt enable block: clear-enable and set-enable views of one
// shared enable store for lines 56..59, and gating of raw requests.
// Assumes raw interrupt requests come from logic on ref_clk.
`timescale 1ns/10ps
`default_nettype none
module irq_enable_upper (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic clkEn,
    // Register port
    input  wire logic [3:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output var  logic [31:0] regRdata,
    // Interrupt lines
    input  wire logic [irq_enable_pkg::LineCount-1:0] irqRaw,
    output var  logic [irq_enable_pkg::LineCount-1:0] irqToCore,
    output var  logic [irq_enable_pkg::LineCount-1:0] irqEnabled
);
    typedef struct packed {
        logic [31:0] rdata;
        logic [irq_enable_pkg::LineCount-1:0] gated;
    } state_type;

    state_type state_q;
    state_type state_d;
    irq_enable_pkg::reg_req_type req;

    logic [irq_enable_pkg::LineCount-1:0] setStb;
    logic [irq_enable_pkg::LineCount-1:0] clrStb;
    logic [irq_enable_pkg::LineCount-1:0] enBits;
    logic [irq_enable_pkg::LineCount-1:0] wrLines;

    // Bundle the port
    always_comb begin
        req.addr  = regAddr;
        req.wdata = regWdata;
        req.wr    = regWr;
        req.rd    = regRd;
    end

    // Only bits 24..27 reach the store; bits 28..31 are dropped here
    // and a zero bit does nothing
    assign wrLines = req.wdata[irq_enable_pkg::LineLsb +:
                               irq_enable_pkg::LineCount]; // see RULE4
    assign clrStb = (req.wr &&
        req.addr == irq_enable_pkg::DisableUpperIdx)
        ? wrLines : '0; // see RULE1 see RULE2 see RULE5
    assign setStb = (req.wr &&
        req.addr == irq_enable_pkg::EnableUpperIdx)
        ? wrLines : '0;

    // One shared enable bit per line, reached from both views
    genvar i;
    generate
        for (i = 0; i < irq_enable_pkg::LineCount; i++) begin : g_line
            irq_enable_bit u_bit (
                .ref_clk (ref_clk),
                .rst     (rst),
                .clkEn   (clkEn),
                .setEn   (setStb[i]),
                .clrEn   (clrStb[i]),
                .enabled (enBits[i])
            ); // see RULE8
        end
    endgenerate

    // Read data next cycle; unmapped words and reserved bits read zero
    always_comb begin
        state_d       = state_q;
        state_d.rdata = irq_enable_pkg::DisableUpperReset;
        if (req.rd) begin
            case (req.addr)
                irq_enable_pkg::DisableUpperIdx,
                irq_enable_pkg::EnableUpperIdx: begin
                    state_d.rdata[irq_enable_pkg::LineLsb +:
                        irq_enable_pkg::LineCount] = enBits; // see RULE3 see RULE6
                end
                irq_enable_pkg::PendingUpperIdx: begin
                    state_d.rdata[irq_enable_pkg::LineLsb +:
                        irq_enable_pkg::LineCount] = irqRaw;
                end
                default: begin
                    state_d.rdata = irq_enable_pkg::DisableUpperReset;
                end
            endcase
        end
        // Registered gating keeps the core input glitch free
        state_d.gated = irqRaw & enBits; // see RULE8
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= '0; // see RULE7
        end else if (clkEn) begin
            state_q <= state_d;
        end
    end

    assign regRdata   = state_q.rdata;
    assign irqToCore  = state_q.gated;
    assign irqEnabled = enBits;
endmodule : irq_enable_upper
`default_nettype wire

// ### rtl/irq_enable_pkg.sv
// Package: register map, field layout and types of the upper interrupt
// enable block (clear-enable view plus the shared set-enable path).
// Assumes a plain strobe register port on one clock, ref_clk, 20 MHz.
// Operation
// RULE1 - Writing one disables the matching line
// RULE2 - Writing zero leaves enable state unchanged
// RULE3 - Read returns enable state, one enabled
// RULE4 - Bits 24 to 27 map lines 56-59
// RULE5 - Software never writes one to reserved bits
// RULE6 - Reserved bits always read as zero
// RULE7 - All enable bits read zero after reset
// RULE8 - Shared enable storage gates lines to core
package irq_enable_pkg;

    // Register word indices (byte address is four times the index)
    localparam logic [3:0]  DisableUpperIdx = 4'h0;
    localparam logic [3:0]  EnableUpperIdx  = 4'h1;
    localparam logic [3:0]  PendingUpperIdx = 4'h2;

    // Field layout of the upper word
    localparam int          LineLsb   = 24;
    localparam int          LineCount = 4;
    localparam int          FirstLine = 56;

    // Reset values
    localparam logic [31:0] DisableUpperReset = 32'h0000_0000;
    localparam logic [LineCount-1:0] EnableReset = 4'h0;

    // Register port request
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_type;

endpackage : irq_enable_pkg

// ### rtl/irq_enable_bit.sv
// One enable bit per interrupt line, with set and clear strobes.
// Assumes strobes are same-clock single-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
module irq_enable_bit (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic clkEn,
    // Control
    input  wire logic setEn,
    input  wire logic clrEn,
    // State
    output var  logic enabled
);
    typedef struct packed {
        logic en;
    } state_type;

    state_type state_q;
    state_type state_d;

    // Clear wins on a simultaneous write: software asked to disable
    always_comb begin
        state_d = state_q;
        if (setEn) begin
            state_d.en = 1'b1;
        end
        if (clrEn) begin
            state_d.en = 1'b0; // see RULE1
        end
    end

    // Lines start disabled
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= '0; // see RULE7
        end else if (clkEn) begin
            state_q <= state_d;
        end
    end

    assign enabled = state_q.en;
endmodule : irq_enable_bit
`default_nettype wire

// ### testbench/irq_enable_upper_chk.sv
// Checker for the upper enable block, bound to its top module's ports.
// Assumes one clock domain and the word index map of the package.
`timescale 1ns/10ps
`default_nettype none
module irq_enable_upper_chk (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        clkEn,
    // Register port
    input wire logic [3:0]  regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [31:0] regRdata,
    // Interrupt lines
    input wire logic [3:0]  irqRaw,
    input wire logic [3:0]  irqToCore,
    input wire logic [3:0]  irqEnabled
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Accepted writes to the clear and set views
    sequence s_clr; clkEn && regWr && regAddr == 4'h0; endsequence
    sequence s_set; clkEn && regWr && regAddr == 4'h1; endsequence
    property p_clr; s_clr |=> irqEnabled ==
        ($past(irqEnabled) & ~$past(regWdata[27:24])); endproperty
    property p_keep; s_clr ##0 regWdata[27:24] == 4'h0
        |=> $stable(irqEnabled); endproperty
    property p_set; s_set |=> irqEnabled ==
        ($past(irqEnabled) | $past(regWdata[27:24])); endproperty
    property p_read; clkEn && regRd && regAddr == 4'h0
        |=> regRdata == {4'h0, $past(irqEnabled), 24'h00_0000}; endproperty
    property p_rsvd; regRdata[31:28] == 4'h0; endproperty
    property p_boot; $fell(rst) |-> irqEnabled == 4'h0; endproperty
    // Gating sees the enables of the cycle the request was sampled in
    property p_gate; clkEn |=>
        irqToCore == ($past(irqRaw) & $past(irqEnabled)); endproperty
    a_clr: assert property (p_clr) else $error("clear wrong");
    a_keep: assert property (p_keep) else $error("zero changed");
    a_set: assert property (p_set) else $error("set wrong");
    a_read: assert property (p_read) else $error("read wrong");
    a_rsvd: assert property (p_rsvd) else $error("reserved set");
    a_boot: assert property (p_boot) else $error("reset wrong");
    a_gate: assert property (p_gate) else $error("gate wrong");
endmodule : irq_enable_upper_chk
bind irq_enable_upper irq_enable_upper_chk u_chk (.*);
`default_nettype wire

// ### testbench/irq_enable_upper_tb.sv
// Self-checking bench for the upper enable block: random set and clear
// writes with read-back. Assumes the checker is bound alongside.
`timescale 1ns/10ps
`default_nettype none
module irq_enable_upper_tb;
    logic ref_clk = 0, rst = 1, clkEn = 1, regWr = 0, regRd = 0;
    logic [3:0]  regAddr = 4'h0, irqRaw = 4'h0, expEn = 4'h0;
    logic [31:0] regWdata = 32'h0000_0000, v;
    logic [31:0] regRdata;
    logic [3:0]  irqToCore, irqEnabled;
    int miscompares = 0, num_checks = 0;
    always #25 ref_clk = ~ref_clk;
    irq_enable_upper u_irq_enable_upper (.ref_clk(ref_clk), .rst(rst),
        .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .irqRaw(irqRaw), .irqToCore(irqToCore), .irqEnabled(irqEnabled));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // Write left standing; the next task's edge ends it back to back
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWr <= 1; regRd <= 0; regAddr <= a; regWdata <= d;
    endtask : wr
    // Raw lines change with each read; the pending view reports them
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        logic [3:0] r;
        r = $urandom;
        if (a == 4'h2) exp = {4'h0, r, 24'h00_0000};
        @(posedge ref_clk);
        regRd <= 1; regWr <= 0; regAddr <= a; irqRaw <= r;
        @(posedge ref_clk);
        regRd <= 0;
        #1 chk(regRdata, exp);
    endtask : rd
    function automatic logic [31:0] view(input logic [3:0] e);
        return {4'h0, e, 24'h00_0000};
    endfunction : view
    task automatic close_out;
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    initial begin
        #100us;
        miscompares++;
        close_out();
    end
    initial begin
        void'($urandom(32'h07ba_e404));
        repeat (5) @(posedge ref_clk);
        rst <= 0;
        rd(4'h0, view(4'h0));
        wr(4'h1, 32'h0F00_0000);
        rd(4'h0, view(4'hF));
        wr(4'h0, 32'h0000_0000);
        rd(4'h0, view(4'hF));
        expEn = 4'hF;
        // Random set and clear masks; reserved bits of the clear view
        // are never written with ones by software
        for (int i = 0; i < 40; i++) begin
            v = $urandom & 32'h0F00_0000;
            wr(i[0] ? 4'h1 : 4'h0, v);
            expEn = i[0] ? (expEn | v[27:24]) : (expEn & ~v[27:24]);
            rd(4'h0, view(expEn));
            chk({28'h000_0000, irqEnabled}, {28'h000_0000, expEn});
            chk({28'h000_0000, irqToCore}, {28'h000_0000, irqRaw & expEn});
            rd(4'h2, 32'h0000_0000);
        end
        rd(4'h3, 32'h0000_0000);
        close_out();
    end
endmodule : irq_enable_upper_tb
`default_nettype wire
